// file: common/nbu_pkg.sv
`default_nettype none
package nbu_pkg;
   ////////////////////////////////////////////////////////////////////////
   // device register map (special-function-register addresses)
   localparam logic [7:0]  NBU_SFR_CTRL      = 8'h98;
   localparam logic [7:0]  NBU_SFR_DATA      = 8'h99;
   localparam logic [7:0]  NBU_CTRL_RST      = 8'h40;
   localparam logic [7:0]  NBU_DATA_RST      = 8'h00;
   // serial_port_control field positions
   localparam int          NBU_B_MODE        = 7;
   localparam int          NBU_B_ONE         = 6;
   localparam int          NBU_B_FILT        = 5;
   localparam int          NBU_B_REN         = 4;
   localparam int          NBU_B_TB8         = 3;
   localparam int          NBU_B_RB8         = 2;
   localparam int          NBU_B_TI          = 1;
   localparam int          NBU_B_RI          = 0;
   // frame lengths in bits, start and stop included
   localparam logic [3:0]  NBU_BITS_8        = 4'ha;
   localparam logic [3:0]  NBU_BITS_9        = 4'hb;
   ////////////////////////////////////////////////////////////////////////
   // remote end register map (axi4-lite byte addresses)
   localparam logic [7:0]  NBU_R_TX          = 8'h00;
   localparam logic [7:0]  NBU_R_RX          = 8'h04;
   localparam logic [7:0]  NBU_R_STAT        = 8'h08;
   localparam logic [7:0]  NBU_R_CFG         = 8'h0c;
   localparam logic [1:0]  NBU_RESP_OKAY     = 2'h0;
   localparam logic [1:0]  NBU_RESP_SLVERR   = 2'h2;
   // remote bit timing
   localparam int          NBU_CLK_HZ        = 125_000_000;
   localparam int          NBU_BAUD          = 115200;
   localparam logic [15:0] NBU_BIT_CYCLES    = 16'(NBU_CLK_HZ / NBU_BAUD);
   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [0:0] {
      NBU_RX_IDLE = 1'b0,
      NBU_RX_BUSY = 1'b1
   } nbu_rx_st_t;
endpackage : nbu_pkg
`default_nettype wire

// file: common/nbu_link_if.sv
`default_nettype none
interface nbu_link_if;
   // device transmit line, remote receives it
   logic serial_out_line;
   // remote transmit line, device receives it
   logic serial_in_line;
   modport dev (output serial_out_line, input serial_in_line);
   modport far (input serial_out_line, output serial_in_line);
endinterface : nbu_link_if
`default_nettype wire

// file: logic/nbu_port_dev.sv
// How it works
// RL1 - nine-bit frame: start, eight data, ninth, stop
// RL2 - ninth sent bit comes from control bit 3
// RL3 - ninth received bit stored in bit 2
// RL4 - only a data buffer write starts sending
// RL5 - transmit done set when stop bit begins
// RL6 - receiver takes frames only when enabled
// RL7 - load only if receive done clear, filter met
// RL8 - refused frame leaves latch and flags alone
// RL9 - eight-bit filter needs stop bit high
// RL10 - eight-bit mode stores stop in ninth bit
// RL11 - receive done set when stop bit sampled
// RL12 - software alone clears both done flags
// RL13 - interrupt while either flag set and enabled
// RL14 - control bit 7 picks eight or nine bits
// RL15 - control bit 6 reads one, ignores writes
// RL16 - data reads return receive latch only
// RL17 - master marks address bytes with ninth high
// RL18 - slave software toggles filter around messages
// RL19 - software picks timer reload for baud
// RL20 - bit time is two baud timer overflows
// RL21 - start edge reloads receive baud timer
// RL22 - eight-bit frame: start, eight data, stop
// RL23 - start is falling edge, sample mid bit
`default_nettype none
module nbu_port_dev (
   // clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // special-function-register bus
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic [7:0] sfr_wdata,
   input  wire logic       sfr_rd,
   output logic      [7:0] sfr_rdata,
   // baud timer reload and interrupt
   input  wire logic [7:0] baud_reload_byte,
   input  wire logic       port_int_enable,
   output logic            port_irq,
   // serial link
   nbu_link_if.dev         link
);
   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic                mode;
      logic                filt;
      logic                ren;
      logic                tb8;
      logic                rb8;
      logic                ti;
      logic                ri;
      logic [7:0]          rbuf;
      logic [7:0]          rdata;
      logic                irq;
      logic [7:0]          tx_tmr;
      logic                tx_half;
      logic                tx_busy;
      logic [10:0]         tx_sh;
      logic [3:0]          tx_cnt;
      logic                tx_line;
      logic [7:0]          rx_tmr;
      logic                rx_half;
      nbu_pkg::nbu_rx_st_t rx_st;
      logic [3:0]          rx_cnt;
      logic [8:0]          rx_sh;
      logic                rx_prev;
   } nbu_dev_st_t;

   localparam nbu_dev_st_t DEV_RST = '{
      mode: 1'b0, filt: 1'b0, ren: 1'b0, tb8: 1'b0, rb8: 1'b0, ti: 1'b0, ri: 1'b0,
      rbuf: nbu_pkg::NBU_DATA_RST, rdata: 8'h00, irq: 1'b0,
      tx_tmr: 8'h00, tx_half: 1'b0, tx_busy: 1'b0, tx_sh: 11'h7ff, tx_cnt: 4'h0,
      tx_line: 1'b1, rx_tmr: 8'h00, rx_half: 1'b0, rx_st: nbu_pkg::NBU_RX_IDLE,
      rx_cnt: 4'h0, rx_sh: 9'h000, rx_prev: 1'b1
   };

   nbu_dev_st_t q;
   nbu_dev_st_t d;
   logic        line;
   logic        tx_ovf;
   logic        rx_ovf;
   logic        tx_tick;
   logic        rx_smp;
   logic        ninth;
   logic        ok;
   logic [7:0]  rx_byte;
   logic [3:0]  nbits;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      d       = q;
      line    = link.serial_in_line;
      nbits   = q.mode ? nbu_pkg::NBU_BITS_9 : nbu_pkg::NBU_BITS_8;  // see RL14
      ninth   = 1'b0;
      ok      = 1'b0;
      rx_byte = 8'h00;

      // baud timers count up from the reload byte; two overflows per bit
      tx_ovf   = q.tx_tmr == 8'hff;
      rx_ovf   = q.rx_tmr == 8'hff;
      d.tx_tmr = tx_ovf ? baud_reload_byte : q.tx_tmr + 8'h01;
      d.rx_tmr = rx_ovf ? baud_reload_byte : q.rx_tmr + 8'h01;
      if (tx_ovf) begin
         d.tx_half = ~q.tx_half;
      end
      if (rx_ovf) begin
         d.rx_half = ~q.rx_half;
      end
      tx_tick = tx_ovf & q.tx_half;                                     // see RL20
      rx_smp  = rx_ovf & ~q.rx_half & (q.rx_st == nbu_pkg::NBU_RX_BUSY); // see RL20

      // control writes; bit 6 has no storage
      if (sfr_wr && sfr_addr == nbu_pkg::NBU_SFR_CTRL) begin            // see RL15
         d.mode = sfr_wdata[nbu_pkg::NBU_B_MODE];                       // see RL14
         d.filt = sfr_wdata[nbu_pkg::NBU_B_FILT];
         d.ren  = sfr_wdata[nbu_pkg::NBU_B_REN];
         d.tb8  = sfr_wdata[nbu_pkg::NBU_B_TB8];
         d.rb8  = sfr_wdata[nbu_pkg::NBU_B_RB8];
         d.ti   = sfr_wdata[nbu_pkg::NBU_B_TI];                         // see RL12
         d.ri   = sfr_wdata[nbu_pkg::NBU_B_RI];                         // see RL12
      end

      // transmit shifter, one bit per tick, line idles high
      if (tx_tick && q.tx_busy) begin
         if (q.tx_cnt == 4'h0) begin
            d.tx_busy = 1'b0;
         end else begin
            d.tx_line = q.tx_sh[0];
            d.tx_sh   = {1'b1, q.tx_sh[10:1]};
            d.tx_cnt  = q.tx_cnt - 4'h1;
            if (q.tx_cnt == 4'h1) begin
               d.ti = 1'b1;                                             // see RL5
            end
         end
      end

      // a data write restarts the shifter with a new frame
      if (sfr_wr && sfr_addr == nbu_pkg::NBU_SFR_DATA) begin            // see RL4
         if (q.mode) begin
            d.tx_sh = {1'b1, q.tb8, sfr_wdata, 1'b0};                   // see RL1, RL2
         end else begin
            d.tx_sh = {2'b11, sfr_wdata, 1'b0};                         // see RL22
         end
         d.tx_cnt  = nbits;
         d.tx_busy = 1'b1;
      end

      // receiver
      d.rx_prev = line;
      if (q.rx_st == nbu_pkg::NBU_RX_IDLE) begin
         if (q.ren && q.rx_prev && !line) begin                         // see RL6, RL23
            d.rx_st   = nbu_pkg::NBU_RX_BUSY;
            d.rx_tmr  = baud_reload_byte;                               // see RL21
            d.rx_half = 1'b0;
            d.rx_cnt  = 4'h0;
         end
      end else if (rx_smp) begin                                        // see RL23
         if (q.rx_cnt == 4'h0 && line) begin
            d.rx_st = nbu_pkg::NBU_RX_IDLE;
         end else if (q.rx_cnt == nbits - 4'h1) begin
            d.rx_st = nbu_pkg::NBU_RX_IDLE;
            if (q.mode) begin
               ninth   = q.rx_sh[8];                                    // see RL3
               rx_byte = q.rx_sh[7:0];
            end else begin
               ninth   = line;                                          // see RL10
               rx_byte = q.rx_sh[8:1];
            end
            ok = !q.ri && (!q.filt || ninth);                           // see RL7, RL9
            if (ok) begin                                               // see RL8
               d.rbuf = rx_byte;
               d.rb8  = ninth;
               d.ri   = 1'b1;                                           // see RL11
            end
         end else begin
            d.rx_sh  = {line, q.rx_sh[8:1]};
            d.rx_cnt = q.rx_cnt + 4'h1;
         end
      end

      // reads: data location returns the receive latch
      if (sfr_rd) begin
         if (sfr_addr == nbu_pkg::NBU_SFR_CTRL) begin
            d.rdata = {q.mode, 1'b1, q.filt, q.ren, q.tb8, q.rb8, q.ti, q.ri}; // see RL15
         end else if (sfr_addr == nbu_pkg::NBU_SFR_DATA) begin
            d.rdata = q.rbuf;                                           // see RL16
         end else begin
            d.rdata = 8'h00;
         end
      end

      d.irq = port_int_enable & (d.ti | d.ri);                          // see RL13
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= DEV_RST;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign sfr_rdata            = q.rdata;
   assign port_irq             = q.irq;
   assign link.serial_out_line = q.tx_line;
endmodule : nbu_port_dev
`default_nettype wire

// file: logic/nbu_remote.sv
// Implementation choice: the AXI4-Lite slave port.
`default_nettype none
module nbu_remote (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [7:0]  awaddr,
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   output logic             bvalid,
   input  wire logic        bready,
   output logic      [1:0]  bresp,
   // axi4-lite read
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [7:0]  araddr,
   output logic             rvalid,
   input  wire logic        rready,
   output logic      [31:0] rdata,
   output logic      [1:0]  rresp,
   // serial link
   nbu_link_if.far          link
);
   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic                awready;
      logic                wready;
      logic                bvalid;
      logic [1:0]          bresp;
      logic [7:0]          awaddr;
      logic [31:0]         wdata;
      logic                arready;
      logic                rvalid;
      logic [1:0]          rresp;
      logic [31:0]         rdata;
      logic                nine;
      logic                ren;
      logic [15:0]         period;
      logic                tx_busy;
      logic                tx_line;
      logic [9:0]          tx_sh;
      logic [3:0]          tx_left;
      logic [15:0]         tx_cnt;
      nbu_pkg::nbu_rx_st_t rx_st;
      logic                rx_prev;
      logic [15:0]         rx_cnt;
      logic [3:0]          rx_idx;
      logic [8:0]          rx_sh;
      logic [8:0]          rx_data;
      logic                rx_valid;
      logic                rx_err;
   } nbu_rem_st_t;

   localparam nbu_rem_st_t REM_RST = '{
      awready: 1'b1, wready: 1'b1, bvalid: 1'b0, bresp: 2'h0, awaddr: 8'h00,
      wdata: 32'h0, arready: 1'b1, rvalid: 1'b0, rresp: 2'h0, rdata: 32'h0,
      nine: 1'b0, ren: 1'b0, period: nbu_pkg::NBU_BIT_CYCLES, tx_busy: 1'b0,
      tx_line: 1'b1, tx_sh: 10'h3ff, tx_left: 4'h0, tx_cnt: 16'h0,
      rx_st: nbu_pkg::NBU_RX_IDLE, rx_prev: 1'b1, rx_cnt: 16'h0, rx_idx: 4'h0,
      rx_sh: 9'h000, rx_data: 9'h000, rx_valid: 1'b0, rx_err: 1'b0
   };

   nbu_rem_st_t q;
   nbu_rem_st_t d;
   logic        line;
   logic [3:0]  nbits;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      d     = q;
      line  = link.serial_out_line;
      nbits = q.nine ? nbu_pkg::NBU_BITS_9 : nbu_pkg::NBU_BITS_8;

      // write channels taken independently; strobes are not used
      if (awvalid && q.awready) begin
         d.awaddr  = awaddr;
         d.awready = 1'b0;
      end
      if (wvalid && q.wready) begin
         d.wdata  = wdata;
         d.wready = 1'b0;
      end
      if (q.bvalid && bready) begin
         d.bvalid  = 1'b0;
         d.awready = 1'b1;
         d.wready  = 1'b1;
      end

      // transmitter
      if (q.tx_busy) begin
         if (q.tx_cnt == 16'h0) begin
            d.tx_cnt = q.period - 16'h1;
            if (q.tx_left == 4'h0) begin
               d.tx_busy = 1'b0;
            end else begin
               d.tx_line = q.tx_sh[0];
               d.tx_sh   = {1'b1, q.tx_sh[9:1]};
               d.tx_left = q.tx_left - 4'h1;
            end
         end else begin
            d.tx_cnt = q.tx_cnt - 16'h1;
         end
      end

      // commit a write once address and data are both held
      if (!q.awready && !q.wready && !q.bvalid) begin
         d.bvalid = 1'b1;
         d.bresp  = nbu_pkg::NBU_RESP_OKAY;
         case (q.awaddr)
            nbu_pkg::NBU_R_TX: begin
               if (!q.tx_busy) begin
                  d.tx_busy = 1'b1;
                  d.tx_line = 1'b0;
                  // bit 8 of the word marks an address byte
                  d.tx_sh   = q.nine ? {1'b1, q.wdata[8:0]} : {2'b11, q.wdata[7:0]}; // see RL17, RL1, RL22
                  d.tx_left = nbits - 4'h1;
                  d.tx_cnt  = q.period - 16'h1;
               end
            end
            nbu_pkg::NBU_R_CFG: begin
               d.nine   = q.wdata[0];
               d.ren    = q.wdata[1];
               d.period = q.wdata[31:16];
            end
            nbu_pkg::NBU_R_RX, nbu_pkg::NBU_R_STAT: begin
               d.bresp = nbu_pkg::NBU_RESP_OKAY;
            end
            default: begin
               d.bresp = nbu_pkg::NBU_RESP_SLVERR;
            end
         endcase
      end

      // read channel; reading the rx word clears its valid flag
      if (arvalid && q.arready) begin
         d.arready = 1'b0;
         d.rvalid  = 1'b1;
         d.rresp   = nbu_pkg::NBU_RESP_OKAY;
         case (araddr)
            nbu_pkg::NBU_R_TX: begin
               d.rdata = 32'h0;
            end
            nbu_pkg::NBU_R_RX: begin
               d.rdata    = {22'h0, q.rx_err, q.rx_data};
               d.rx_valid = 1'b0;
            end
            nbu_pkg::NBU_R_STAT: begin
               d.rdata = {29'h0, q.rx_err, q.rx_valid, q.tx_busy};
            end
            nbu_pkg::NBU_R_CFG: begin
               d.rdata = {q.period, 14'h0, q.ren, q.nine};
            end
            default: begin
               d.rdata = 32'h0;
               d.rresp = nbu_pkg::NBU_RESP_SLVERR;
            end
         endcase
      end
      if (q.rvalid && rready) begin
         d.rvalid  = 1'b0;
         d.arready = 1'b1;
      end

      // receiver; a new frame sets valid after any clear above
      d.rx_prev = line;
      if (q.rx_st == nbu_pkg::NBU_RX_IDLE) begin
         if (q.ren && q.rx_prev && !line) begin
            d.rx_st  = nbu_pkg::NBU_RX_BUSY;
            d.rx_cnt = {1'b0, q.period[15:1]};
            d.rx_idx = 4'h0;
         end
      end else if (q.rx_cnt != 16'h0) begin
         d.rx_cnt = q.rx_cnt - 16'h1;
      end else begin
         d.rx_cnt = q.period - 16'h1;
         if (q.rx_idx == 4'h0 && line) begin
            d.rx_st = nbu_pkg::NBU_RX_IDLE;
         end else if (q.rx_idx == nbits - 4'h1) begin
            d.rx_st    = nbu_pkg::NBU_RX_IDLE;
            d.rx_data  = q.nine ? q.rx_sh : {1'b0, q.rx_sh[8:1]};
            d.rx_err   = !line;
            d.rx_valid = 1'b1;
         end else begin
            d.rx_sh  = {line, q.rx_sh[8:1]};
            d.rx_idx = q.rx_idx + 4'h1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= REM_RST;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign awready             = q.awready;
   assign wready              = q.wready;
   assign bvalid              = q.bvalid;
   assign bresp               = q.bresp;
   assign arready             = q.arready;
   assign rvalid              = q.rvalid;
   assign rdata               = q.rdata;
   assign rresp               = q.rresp;
   assign link.serial_in_line = q.tx_line;
endmodule : nbu_remote
`default_nettype wire

// file: verif/nbu_link_checker.sv
`default_nettype none
module nbu_link_checker #(
   parameter int BIT = 16
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // serial link
   input wire logic serial_out_line,
   input wire logic serial_in_line
);
   timeunit 1ns;
   timeprecision 1ps;

   ////////////////////////////////////////////////////////////////////////
   // length of the present level run on each line, in cycles
   logic [15:0] out_run_q;
   logic [15:0] in_run_q;
   logic        out_prev_q;
   logic        in_prev_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_run_q  <= 16'(BIT);
         in_run_q   <= 16'(BIT);
         out_prev_q <= 1'b1;
         in_prev_q  <= 1'b1;
      end else begin
         out_prev_q <= serial_out_line;
         in_prev_q  <= serial_in_line;
         out_run_q  <= (serial_out_line != out_prev_q) ? 16'h0001 : out_run_q + 16'h0001;
         in_run_q   <= (serial_in_line != in_prev_q) ? 16'h0001 : in_run_q + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // low runs are whole bits, at most start plus nine zero bits
   AST_OUT_LOW_RUN: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(serial_out_line) |-> (out_run_q % BIT == 0) && (out_run_q <= 10 * BIT))
      else $error("device line low run not a whole number of bits");
   AST_IN_LOW_RUN: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(serial_in_line) |-> (in_run_q % BIT == 0) && (in_run_q <= 10 * BIT))
      else $error("remote line low run not a whole number of bits");
   // a start bit never follows less than a full stop bit
   AST_OUT_HIGH_MIN: assert property (@(posedge aclk) disable iff (!aresetn)
      (!serial_out_line && out_prev_q) |-> out_run_q >= BIT)
      else $error("device line high run shorter than one bit");
   AST_IN_HIGH_MIN: assert property (@(posedge aclk) disable iff (!aresetn)
      (!serial_in_line && in_prev_q) |-> in_run_q >= BIT)
      else $error("remote line high run shorter than one bit");
   AST_OUT_START_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(serial_out_line) |=> !serial_out_line [*8])
      else $error("device start bit too short");
   AST_IN_START_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(serial_in_line) |=> !serial_in_line [*8])
      else $error("remote start bit too short");
   // both lines idle high when reset ends
   AST_OUT_RESET_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> serial_out_line ##1 serial_out_line)
      else $error("device line not idle after reset");
   AST_IN_RESET_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> serial_in_line ##1 serial_in_line)
      else $error("remote line not idle after reset");
endmodule : nbu_link_checker
`default_nettype wire

// file: verif/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0]  CTL = nbu_pkg::NBU_SFR_CTRL;
   localparam logic [7:0]  DAT = nbu_pkg::NBU_SFR_DATA;
   localparam logic [1:0]  OK  = nbu_pkg::NBU_RESP_OKAY;
   localparam logic [31:0] C8  = 32'h0010_0002;
   localparam logic [31:0] C9  = 32'h0010_0003;
   localparam logic [31:0] TX_CFG [4] = '{C8, C9, C9, C9};
   localparam logic [7:0]  TX_CTL [4] = '{8'h18, 8'h98, 8'h90, 8'h90};
   localparam logic [7:0]  TX_DAT [4] = '{8'ha5, 8'h3c, 8'hc3, 8'h00};
   localparam logic [31:0] TX_EXP [4] = '{32'h0a5, 32'h13c, 32'h0c3, 32'h000};
   localparam logic [31:0] RX_CFG [7] = '{C8, C9, C9, C9, C9, C9, C8};
   localparam logic [7:0]  RX_CTL [7] = '{8'h10, 8'h90, 8'hb4, 8'hb0, 8'h91, 8'h80, 8'h30};
   localparam logic [31:0] RX_TX  [7] = '{32'h15a, 32'h0e7, 32'h042, 32'h1a6, 32'h111, 32'h177, 32'h0bb};
   localparam logic [7:0]  RX_EXC [7] = '{8'h55, 8'hd1, 8'hf4, 8'hf5, 8'hd1, 8'hc0, 8'h75};
   localparam logic [7:0]  RX_EXD [7] = '{8'h5a, 8'he7, 8'he7, 8'ha6, 8'ha6, 8'ha6, 8'hbb};

   logic aclk = 1'b0, aresetn = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0, port_int_enable = 1'b0, port_irq;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [31:0] wdata = 32'h0, rdata;
   logic [1:0]  bresp, rresp;
   int miscompares = 0, checks_done = 0, cycles = 0;

   always #4 aclk = ~aclk;

   nbu_link_if link ();
   nbu_port_dev u_nbu_port_dev (.aclk(aclk), .aresetn(aresetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .baud_reload_byte(8'hf8),
      .port_int_enable(port_int_enable), .port_irq(port_irq), .link(link));
   nbu_remote u_nbu_remote (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid),
      .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .link(link));
   nbu_link_checker #(.BIT(16)) u_nbu_link_checker (.aclk(aclk), .aresetn(aresetn),
      .serial_out_line(link.serial_out_line), .serial_in_line(link.serial_in_line));

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic end_of_test;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_of_test

   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge aclk);
      sfr_wr <= 1'b1;
      sfr_addr <= a;
      sfr_wdata <= d;
      @(posedge aclk);
      sfr_wr <= 1'b0;
   endtask : sfr_write

   task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge aclk);
      sfr_rd <= 1'b1;
      sfr_addr <= a;
      @(posedge aclk);
      sfr_rd <= 1'b0;
      #1;
      d = sfr_rdata;
   endtask : sfr_read

   task automatic sfr_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      sfr_read(a, d);
      check(what, 32'(exp), 32'(d));
   endtask : sfr_chk

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= a;
      wdata <= d;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      check("bresp", 32'(er), 32'(bresp));
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_read

   task automatic axi_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      axi_read(a, d, r);
      check("rdata", ed, d);
      check("rresp", 32'(er), 32'(r));
   endtask : axi_chk

   // waits on a remote status bit, or on the device tx-done flag when b is negative
   task automatic poll(input int b, input logic v);
      logic [31:0] d;
      logic [7:0]  c;
      logic [1:0]  r;
      int          n;
      n = 0;
      do begin
         if (b < 0) sfr_read(CTL, c);
         else axi_read(nbu_pkg::NBU_R_STAT, d, r);
         n++;
      end while (((b < 0) ? c[nbu_pkg::NBU_B_TI] : d[b]) !== v && n < 400);
      check("poll", 32'(v), 32'((b < 0) ? c[nbu_pkg::NBU_B_TI] : d[b]));
   endtask : poll

   ////////////////////////////////////////////////////////////////////////
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         end_of_test();
      end
   end

   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      sfr_chk("ctrl reset", CTL, nbu_pkg::NBU_CTRL_RST);
      sfr_chk("data reset", DAT, nbu_pkg::NBU_DATA_RST);
      sfr_chk("unmapped", 8'h9a, 8'h00);
      sfr_write(CTL, 8'h00);
      sfr_chk("ctrl bit6", CTL, 8'h40);
      axi_chk(8'h10, 32'h0, nbu_pkg::NBU_RESP_SLVERR);
      axi_write(8'h10, 32'h0, nbu_pkg::NBU_RESP_SLVERR);
      for (int i = 0; i < 4; i++) begin
         repeat (16) @(posedge aclk);
         axi_write(nbu_pkg::NBU_R_CFG, TX_CFG[i], OK);
         axi_chk(nbu_pkg::NBU_R_CFG, TX_CFG[i], OK);
         sfr_write(CTL, TX_CTL[i]);
         port_int_enable <= i[0];
         repeat (2) @(posedge aclk);
         #1 check("irq cleared", 32'h0, 32'(port_irq));
         sfr_write(DAT, TX_DAT[i]);
         sfr_chk("rx latch", DAT, 8'h00);
         poll(-1, 1'b1);
         check("stop level", 32'h1, 32'(link.serial_out_line));
         repeat (2) @(posedge aclk);
         #1 check("irq", 32'(i[0]), 32'(port_irq));
         poll(1, 1'b1);
         axi_chk(nbu_pkg::NBU_R_RX, TX_EXP[i], OK);
      end
      for (int j = 0; j < 7; j++) begin
         axi_write(nbu_pkg::NBU_R_CFG, RX_CFG[j], OK);
         sfr_write(CTL, RX_CTL[j]);
         axi_write(nbu_pkg::NBU_R_TX, RX_TX[j], OK);
         poll(0, 1'b0);
         repeat (16) @(posedge aclk);
         sfr_chk("rx ctrl", CTL, RX_EXC[j]);
         sfr_chk("rx data", DAT, RX_EXD[j]);
      end
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
